// ---- hw/mcmc_pkg.sv ----
// Constants, types and register map of the master clock and mode control block
package mcmc_pkg;
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned RST_HOLD_NS = 10_000;
	localparam int unsigned RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SETTLE_US = 100;
	localparam int unsigned SETTLE_CYC_DEF = SETTLE_US * (CLK_HZ / 1_000_000);
	localparam int unsigned REF_TO_US = 250;
	localparam int unsigned REF_TO_CYC_DEF = REF_TO_US * (CLK_HZ / 1_000_000);
	localparam int unsigned CNT_W = 20;
	localparam int unsigned RCNT_W = 12;
	localparam int unsigned ACC_W = 32;
	localparam longint unsigned MCLK_E1_HZ = 2_048_000;
	localparam longint unsigned MCLK_T1_HZ = 1_544_000;
	localparam logic [ACC_W-1:0] INC_E1 = ACC_W'((MCLK_E1_HZ << ACC_W) / 64'(CLK_HZ));
	localparam logic [ACC_W-1:0] INC_T1 = ACC_W'((MCLK_T1_HZ << ACC_W) / 64'(CLK_HZ));
	localparam logic [2:0] EQ_E1_PREFIX = 3'h7;
	localparam int unsigned NCHAN = 8;
	localparam int unsigned WB_AW = 8;
	localparam int unsigned WB_DW = 32;
	localparam logic [WB_AW-1:0] ADDR_CTRL = 8'h00;
	localparam logic [WB_AW-1:0] ADDR_EQ = 8'h04;
	localparam logic [WB_AW-1:0] ADDR_STAT = 8'h08;

	typedef enum logic [2:0] {
		SRC_E1_FULL = 3'b000,
		SRC_T1_FULL = 3'b001,
		SRC_8K = 3'b010,
		SRC_16K = 3'b011,
		SRC_56K = 3'b100,
		SRC_64K = 3'b101,
		SRC_128K = 3'b110,
		SRC_256K = 3'b111
	} mcmc_src_t;

	typedef enum logic [2:0] {
		TERM_EXT = 3'b000,
		TERM_100 = 3'b001,
		TERM_110 = 3'b010,
		TERM_75 = 3'b011,
		TERM_120 = 3'b100
	} mcmc_term_t;

	typedef struct packed {
		logic rate;
		mcmc_src_t src;
	} mcmc_cfg_t;

	typedef struct packed {
		logic rx_on;
		mcmc_cfg_t cfg;
	} mcmc_ctrl_t;

	typedef struct packed {
		mcmc_term_t term;
		logic factory;
		logic dev_reset;
		logic host_mode;
		logic t1_mode;
		logic ref_alive;
		logic valid;
	} mcmc_stat_t;

	typedef struct packed {
		logic host_mode;
		logic imp_hi;
		logic imp_lo;
		logic tx_term;
		logic rx_term;
		logic ict_n;
		logic rx_on;
		mcmc_cfg_t cfg;
		logic [4:0] eq;
		logic hw_reset_n;
	} mcmc_pins_t;

	localparam int unsigned CTRL_W = $bits(mcmc_ctrl_t);
	localparam mcmc_ctrl_t CTRL_RST = mcmc_ctrl_t'(5'h00);
	localparam mcmc_pins_t PINS_IDLE = mcmc_pins_t'(17'h00801);
	localparam logic [4:0] EQ_RST = 5'h00;
endpackage

// ---- hw/mcmc_synth.sv ----
// Master clock synthesizer with reference watchdog and settle timer
module mcmc_synth
	import mcmc_pkg::*;
#(
	parameter int unsigned SETTLE_CYC = SETTLE_CYC_DEF,
	parameter int unsigned REF_TO_CYC = REF_TO_CYC_DEF
) (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire mcmc_cfg_t cfg_in,
	input wire logic hold_in,
	input wire logic e1_rise_in,
	input wire logic t1_rise_in,
	output logic mclk_out,
	output logic valid_out,
	output logic ref_alive_out
);
	logic [ACC_W-1:0] acc_reg, acc_next;
	logic [CNT_W-1:0] settle_reg, settle_next, idle_reg, idle_next;
	mcmc_cfg_t cfg_reg, cfg_next;
	logic mclk_reg, mclk_next, valid_reg, valid_next, ref_rise, alive;
	logic [7:0] gap_reg, gap_next;
	logic clean_reg, clean_next;

	always_comb begin
		// Only the full-rate T1 code looks at the T1 input
		ref_rise = (cfg_in.src == SRC_T1_FULL) ? t1_rise_in : e1_rise_in;
		alive = idle_reg != CNT_W'(REF_TO_CYC);
		acc_next = acc_reg + (cfg_in.rate ? INC_T1 : INC_E1);
		mclk_next = acc_reg[ACC_W-1];
		cfg_next = cfg_in;
		if (ref_rise) begin
			idle_next = '0;
		end else if (alive) begin
			idle_next = idle_reg + 1'b1;
		end else begin
			idle_next = idle_reg;
		end
		// Settle restarts on any change, and waits while the reference is absent
		if (hold_in || cfg_in != cfg_reg) begin
			settle_next = CNT_W'(SETTLE_CYC);
		end else if (settle_reg != '0 && alive) begin
			settle_next = settle_reg - 1'b1;
		end else begin
			settle_next = settle_reg;
		end
		valid_next = settle_reg == '0 && alive && !hold_in && cfg_in == cfg_reg;
		// A period counts only if valid held from its first edge to its last
		gap_next = (mclk_next && !mclk_reg) ? 8'h01 : gap_reg + 8'h01;
		clean_next = (mclk_next && !mclk_reg) ? valid_reg : clean_reg && valid_reg;
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			acc_reg <= '0;
			mclk_reg <= 1'b0;
			cfg_reg <= mcmc_cfg_t'(4'h0);
			idle_reg <= CNT_W'(REF_TO_CYC);
			settle_reg <= CNT_W'(SETTLE_CYC);
			valid_reg <= 1'b0;
		end else begin
			acc_reg <= acc_next;
			mclk_reg <= mclk_next;
			cfg_reg <= cfg_next;
			idle_reg <= idle_next;
			settle_reg <= settle_next;
			valid_reg <= valid_next;
		end
	end

	assign mclk_out = mclk_reg;
	assign valid_out = valid_reg;
	assign ref_alive_out = alive;

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			gap_reg <= 8'h00;
			clean_reg <= 1'b0;
		end else begin
			gap_reg <= gap_next;
			clean_reg <= clean_next;
		end
	end

	a_mclk_e1_period: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		($rose(mclk_reg) && valid_reg && $past(clean_reg) && !$past(cfg_in.rate))
		|-> $past(gap_reg) inside {[61:62]})
		else $error("E1 master clock period wrong");
	a_mclk_t1_period: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		($rose(mclk_reg) && valid_reg && $past(clean_reg) && $past(cfg_in.rate))
		|-> $past(gap_reg) inside {[80:81]})
		else $error("T1 master clock period wrong");
	a_lowrate_ignores_t1: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
		(cfg_in.src >= SRC_8K && t1_rise_in && !e1_rise_in && alive) |=> idle_reg != '0)
		else $error("T1 input used with low-rate reference");
endmodule

// ---- hw/mcmc_top.sv ----
// Master clock and mode control top with Wishbone register slave
module mcmc_top
	import mcmc_pkg::*;
#(
	parameter int unsigned SETTLE_CYC = SETTLE_CYC_DEF,
	parameter int unsigned REF_TO_CYC = REF_TO_CYC_DEF
) (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [WB_AW-1:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [WB_DW-1:0] wb_dat_in,
	output logic [WB_DW-1:0] wb_dat_out,
	output logic wb_ack_out,
	input wire mcmc_pins_t pins_in,
	input wire logic e1_master_clock_in,
	input wire logic t1_master_clock_in,
	output logic master_clock_out,
	output logic master_clock_valid_out,
	output logic [NCHAN-1:0] rx_enable_out,
	output logic line_t1_mode_out,
	output mcmc_term_t termination_out,
	output logic pin_drive_en_out,
	output logic factory_test_out,
	output logic device_reset_out
);
	localparam int unsigned SYNC_W = $bits(mcmc_pins_t) + 2;

	logic [SYNC_W-1:0] sync1_reg, sync2_reg;
	logic [1:0] clk_prev_reg;
	mcmc_pins_t pins_s;
	logic e1_s, t1_s, e1_rise, t1_rise;

	// Pins and board clocks are asynchronous to the system clock
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			// Pulled-up pins start high, so reset shows no false factory entry
			sync1_reg <= {PINS_IDLE, 2'b00};
			sync2_reg <= {PINS_IDLE, 2'b00};
			clk_prev_reg <= 2'h0;
		end else begin
			sync1_reg <= {pins_in, e1_master_clock_in, t1_master_clock_in};
			sync2_reg <= sync1_reg;
			clk_prev_reg <= sync2_reg[1:0];
		end
	end

	always_comb begin
		pins_s = mcmc_pins_t'(sync2_reg[SYNC_W-1:2]);
		e1_s = sync2_reg[1];
		t1_s = sync2_reg[0];
		e1_rise = e1_s && !clk_prev_reg[1];
		t1_rise = t1_s && !clk_prev_reg[0];
	end

	// Reset pin filter; glitches shorter than the hold time are ignored
	logic [RCNT_W-1:0] rcnt_reg, rcnt_next;
	logic dev_rst_reg, dev_rst_next;

	always_comb begin
		if (pins_s.hw_reset_n) begin
			rcnt_next = '0;
		end else if (rcnt_reg <= RCNT_W'(RST_HOLD_CYC)) begin
			rcnt_next = rcnt_reg + 1'b1;
		end else begin
			rcnt_next = rcnt_reg;
		end
		dev_rst_next = !pins_s.hw_reset_n && rcnt_reg > RCNT_W'(RST_HOLD_CYC);
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rcnt_reg <= '0;
			dev_rst_reg <= 1'b0;
		end else begin
			rcnt_reg <= rcnt_next;
			dev_rst_reg <= dev_rst_next;
		end
	end

	// Register slave
	mcmc_ctrl_t ctrl_reg, ctrl_next;
	logic [4:0] eq_reg, eq_next;
	logic ack_reg, ack_next;
	logic [WB_DW-1:0] dat_reg, dat_next;
	mcmc_stat_t stat;
	logic wr_take;

	always_comb begin
		ack_next = wb_cyc_in && wb_stb_in && !ack_reg;
		// Write lands on the edge at which the master sees ack
		wr_take = wb_cyc_in && wb_stb_in && wb_we_in && ack_reg && wb_sel_in[0];
		ctrl_next = ctrl_reg;
		eq_next = eq_reg;
		if (dev_rst_reg) begin
			ctrl_next = CTRL_RST;
			eq_next = EQ_RST;
		end else if (wr_take && wb_adr_in == ADDR_CTRL) begin
			ctrl_next = mcmc_ctrl_t'(wb_dat_in[CTRL_W-1:0]);
		end else if (wr_take && wb_adr_in == ADDR_EQ) begin
			eq_next = wb_dat_in[4:0];
		end
		unique case (wb_adr_in)
			ADDR_CTRL: dat_next = WB_DW'(ctrl_reg);
			ADDR_EQ: dat_next = WB_DW'(eq_reg);
			ADDR_STAT: dat_next = WB_DW'(stat);
			default: dat_next = '0;
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ctrl_reg <= CTRL_RST;
			eq_reg <= EQ_RST;
			ack_reg <= 1'b0;
			dat_reg <= '0;
		end else begin
			ctrl_reg <= ctrl_next;
			eq_reg <= eq_next;
			ack_reg <= ack_next;
			dat_reg <= dat_next;
		end
	end

	assign wb_ack_out = ack_reg;
	assign wb_dat_out = dat_reg;

	// Mode decode
	mcmc_cfg_t cfg_reg, cfg_next;
	mcmc_term_t term_reg, term_next;
	logic t1_reg, t1_next, drive_reg, drive_next, fact_reg, fact_next, rx_on_eff;
	logic [NCHAN-1:0] rx_en_reg;
	logic [4:0] eq_eff;

	always_comb begin
		// One configuration for the whole device, never per channel
		cfg_next = pins_s.host_mode ? ctrl_reg.cfg : pins_s.cfg;
		eq_eff = pins_s.host_mode ? eq_reg : pins_s.eq;
		t1_next = eq_eff[4:2] != EQ_E1_PREFIX;
		rx_on_eff = !dev_rst_reg && (pins_s.host_mode ? ctrl_reg.rx_on : pins_s.rx_on);
		term_next = TERM_EXT;
		if (!pins_s.host_mode && pins_s.tx_term && pins_s.rx_term) begin
			unique case ({pins_s.imp_hi, pins_s.imp_lo})
				2'b00: term_next = TERM_100;
				2'b01: term_next = TERM_110;
				2'b10: term_next = TERM_75;
				2'b11: term_next = TERM_120;
			endcase
		end
		drive_next = pins_s.ict_n;
		fact_next = !pins_s.hw_reset_n && !pins_s.ict_n;
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cfg_reg <= mcmc_cfg_t'(4'h0);
			term_reg <= TERM_EXT;
			t1_reg <= 1'b0;
			drive_reg <= 1'b0;
			fact_reg <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			term_reg <= term_next;
			t1_reg <= t1_next;
			drive_reg <= drive_next;
			fact_reg <= fact_next;
		end
	end

	for (genvar g = 0; g < NCHAN; g++) begin : g_rx
		always_ff @(posedge clk_sys_in or negedge nrst_in) begin
			if (!nrst_in) begin
				rx_en_reg[g] <= 1'b0;
			end else begin
				rx_en_reg[g] <= rx_on_eff;
			end
		end
	end

	logic mclk, mclk_valid, ref_alive;

	mcmc_synth #(
		.SETTLE_CYC(SETTLE_CYC),
		.REF_TO_CYC(REF_TO_CYC)
	) u_synth (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.cfg_in(cfg_reg),
		.hold_in(dev_rst_reg),
		.e1_rise_in(e1_rise),
		.t1_rise_in(t1_rise),
		.mclk_out(mclk),
		.valid_out(mclk_valid),
		.ref_alive_out(ref_alive)
	);

	always_comb begin
		stat.term = term_reg;
		stat.factory = fact_reg;
		stat.dev_reset = dev_rst_reg;
		stat.host_mode = pins_s.host_mode;
		stat.t1_mode = t1_reg;
		stat.ref_alive = ref_alive;
		stat.valid = mclk_valid;
	end

	assign master_clock_out = mclk;
	assign master_clock_valid_out = mclk_valid;
	assign rx_enable_out = rx_en_reg;
	assign line_t1_mode_out = t1_reg;
	assign termination_out = term_reg;
	assign pin_drive_en_out = drive_reg;
	assign factory_test_out = fact_reg;
	assign device_reset_out = dev_rst_reg;

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!nrst_in);

	a_ict_tristate: assert property (!pins_s.ict_n |=> !pin_drive_en_out)
		else $error("Pins driven during in-circuit test");
	a_factory_entry: assert property (
		(!pins_s.hw_reset_n && !pins_s.ict_n) |=> factory_test_out)
		else $error("Factory test not entered");
	a_rx_hw_follow: assert property (
		(!pins_s.host_mode && !dev_rst_reg) |=> rx_enable_out == {NCHAN{$past(pins_s.rx_on)}})
		else $error("Receiver enables do not follow pin");
	a_term_75: assert property (
		(!pins_s.host_mode && pins_s.tx_term && pins_s.rx_term && pins_s.imp_hi
		&& !pins_s.imp_lo) |=> termination_out == TERM_75)
		else $error("Impedance decode wrong");
	a_reset_short: assert property ($fell(pins_s.hw_reset_n) |=> !device_reset_out [*8])
		else $error("Reset entered before hold time");
	a_reset_release: assert property (pins_s.hw_reset_n |=> !device_reset_out)
		else $error("Reset state kept after pin release");
	a_settle_invalid: assert property ($changed(cfg_reg) |=> !master_clock_valid_out [*8])
		else $error("Master clock valid during reconfiguration");
	a_host_cfg: assert property (pins_s.host_mode |=> cfg_reg == $past(ctrl_reg.cfg))
		else $error("Host mode not using control bits");
	a_eq_e1: assert property ((eq_eff[4:2] == EQ_E1_PREFIX) |=> !line_t1_mode_out)
		else $error("E1 equalizer code not giving E1 mode");
	a_ack_one: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("Ack held two cycles");

	// Remaining decode codes, reset and master clock valid checks, and bus timing
	a_term_100: assert property (
		(!pins_s.host_mode && pins_s.tx_term && pins_s.rx_term && !pins_s.imp_hi
		&& !pins_s.imp_lo) |=> termination_out == TERM_100)
		else $error("Impedance decode wrong");
	a_term_110: assert property (
		(!pins_s.host_mode && pins_s.tx_term && pins_s.rx_term && !pins_s.imp_hi
		&& pins_s.imp_lo) |=> termination_out == TERM_110)
		else $error("Impedance decode wrong");
	a_term_120: assert property (
		(!pins_s.host_mode && pins_s.tx_term && pins_s.rx_term && pins_s.imp_hi
		&& pins_s.imp_lo) |=> termination_out == TERM_120)
		else $error("Impedance decode wrong");
	a_term_ext: assert property (
		(pins_s.host_mode || !pins_s.tx_term || !pins_s.rx_term) |=> termination_out == TERM_EXT)
		else $error("Internal termination without both selects");
	a_ict_release: assert property (pins_s.ict_n |=> pin_drive_en_out)
		else $error("Pins floating outside in-circuit test");
	a_factory_exit: assert property (
		(pins_s.hw_reset_n || pins_s.ict_n) |=> !factory_test_out)
		else $error("Factory test without both pins low");
	a_rx_host_follow: assert property (
		(pins_s.host_mode && !dev_rst_reg) |=> rx_enable_out == {NCHAN{$past(ctrl_reg.rx_on)}})
		else $error("Receiver enables do not follow control bit");
	a_hw_cfg: assert property (!pins_s.host_mode |=> cfg_reg == $past(pins_s.cfg))
		else $error("Hardware mode not using select pins");
	a_eq_t1: assert property ((eq_eff[4:2] != EQ_E1_PREFIX) |=> line_t1_mode_out)
		else $error("T1 equalizer code not giving T1 mode");
	a_dev_rst_regs: assert property (dev_rst_reg |=> ctrl_reg == CTRL_RST
		&& eq_reg == EQ_RST && rx_enable_out == '0)
		else $error("Reset state not clearing controls");
	a_valid_in_reset: assert property (dev_rst_reg |=> !master_clock_valid_out)
		else $error("Master clock valid during device reset");
	a_valid_needs_ref: assert property (!ref_alive |=> !master_clock_valid_out)
		else $error("Master clock valid without reference");
	a_ack_timing: assert property ((wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out)
		else $error("Ack not one cycle after request");

	c_factory: cover property ($rose(factory_test_out));
	c_dev_reset: cover property ($rose(device_reset_out));
	c_valid: cover property ($rose(master_clock_valid_out));
	c_host_write: cover property (wr_take && wb_adr_in == ADDR_CTRL);
	c_lowrate: cover property (cfg_reg.src >= SRC_8K && master_clock_valid_out);
endmodule

// ---- testbench/mcmc_board.sv ----
// Board clock sources and strap levels beside the clock and mode control block
module mcmc_board (
	input wire logic single_in,
	input wire logic t1_stop_in,
	output logic e1_clk_out,
	output logic t1_clk_out,
	output logic mfg_test_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic e1_osc = 1'b0;
	logic t1_osc = 1'b0;
	// Periods unrelated to the system clock
	always #97 e1_osc = ~e1_osc;
	always #129 t1_osc = ~t1_osc;
	assign e1_clk_out = e1_osc;
	// With one board clock it drives both inputs
	// A stopped clock stands low, as a dead oscillator would
	assign t1_clk_out = ~t1_stop_in & (single_in ? e1_osc : t1_osc);
	// Manufacturing test strap grounded
	assign mfg_test_out = 1'b0;
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench of the master clock and mode control block
module tb
	import mcmc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int LIMIT = 40000;
	logic clk_sys_in = 1'b0;
	logic nrst_in = 1'b0;
	logic wb_cyc = 1'b0;
	logic wb_we = 1'b0;
	logic [WB_AW-1:0] wb_adr = 8'h00;
	logic [WB_DW-1:0] wb_wdat = 32'h0;
	logic [WB_DW-1:0] wb_rdat;
	logic wb_ack;
	mcmc_pins_t pins = 17'h00801;
	logic single = 1'b1;
	logic t1_stop = 1'b0;
	logic e1c, t1c, mclk, valid, t1m, drv, fact, dres;
	logic [NCHAN-1:0] rx_en;
	mcmc_term_t term;
	logic [WB_DW-1:0] q;
	int failures = 0;
	int tests_run = 0;
	int cyc_cnt = 0;
	always #4 clk_sys_in = ~clk_sys_in;
	mcmc_board i_board (.single_in(single), .t1_stop_in(t1_stop), .e1_clk_out(e1c),
		.t1_clk_out(t1c), .mfg_test_out());
	mcmc_top #(.SETTLE_CYC(32), .REF_TO_CYC(200)) i_dut (.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_cyc), .wb_we_in(wb_we),
		.wb_adr_in(wb_adr), .wb_sel_in(4'hF), .wb_dat_in(wb_wdat), .wb_dat_out(wb_rdat),
		.wb_ack_out(wb_ack), .pins_in(pins), .e1_master_clock_in(e1c),
		.t1_master_clock_in(t1c), .master_clock_out(mclk), .master_clock_valid_out(valid),
		.rx_enable_out(rx_en), .line_t1_mode_out(t1m), .termination_out(term),
		.pin_drive_en_out(drv), .factory_test_out(fact), .device_reset_out(dres));
	task automatic finish_test();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic chk_rng(input string what, input int lo, input int hi, input int got);
		tests_run++;
		if (got < lo || got > hi) begin
			failures++;
			$display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask
	// Pins pass two sync flops and a register, so allow five edges
	task automatic set_pins(input mcmc_pins_t p);
		@(posedge clk_sys_in);
		pins <= p;
		repeat (5) @(posedge clk_sys_in);
	endtask
	// Classic single cycle; the wait ends at ack, or at the bound of 100 edges
	task automatic wb_xfer(input logic we, input logic [WB_AW-1:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys_in);
		wb_cyc <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_wdat <= d;
		n = 0;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (wb_ack !== 1'b1 && n < 100);
		q = wb_rdat;
		wb_cyc <= 1'b0;
		wb_we <= 1'b0;
		if (n >= 100) chk("wb_ack", 1, 0);
	endtask
	task automatic wait_valid(input logic exp, input int lim);
		int n;
		n = 0;
		while (valid !== exp && n < lim) begin
			@(posedge clk_sys_in);
			n++;
		end
		chk("master_clock_valid", {31'h0, exp}, {31'h0, valid});
	endtask
	task automatic period(input int lo, input int hi);
		longint t0;
		@(posedge mclk);
		t0 = $time;
		@(posedge mclk);
		chk_rng("master_clock_period", lo, hi, int'(($time - t0) / 8));
	endtask
	task automatic t_term();
		mcmc_pins_t p;
		mcmc_term_t exp[4];
		exp = '{TERM_100, TERM_110, TERM_75, TERM_120};
		p = pins;
		p.tx_term = 1'b1;
		p.rx_term = 1'b1;
		for (int i = 0; i < 4; i++) begin
			{p.imp_hi, p.imp_lo} = 2'(i);
			set_pins(p);
			chk("termination", 32'(exp[i]), 32'(term));
		end
		p.rx_term = 1'b0;
		set_pins(p);
		chk("termination", 32'(TERM_EXT), 32'(term));
	endtask
	task automatic t_modes();
		mcmc_pins_t p;
		p = pins;
		p.rx_on = 1'b1;
		p.eq = 5'h1C;
		set_pins(p);
		chk("rx_enable", 32'hFF, 32'(rx_en));
		chk("t1_mode", 0, 32'(t1m));
		p.rx_on = 1'b0;
		p.eq = 5'h00;
		p.ict_n = 1'b0;
		set_pins(p);
		chk("rx_enable", 0, 32'(rx_en));
		chk("t1_mode", 1, 32'(t1m));
		chk("pin_drive_en", 0, 32'(drv));
		chk("factory_test", 0, 32'(fact));
		p.hw_reset_n = 1'b0;
		set_pins(p);
		chk("factory_test", 1, 32'(fact));
		p.ict_n = 1'b1;
		p.hw_reset_n = 1'b1;
		set_pins(p);
		chk("factory_test", 0, 32'(fact));
		chk("pin_drive_en", 1, 32'(drv));
	endtask
	// Every source code, the rate alternating so each code runs at one rate; each change must drop valid
	task automatic t_clock();
		mcmc_pins_t p;
		p = pins;
		for (int i = 0; i < 8; i++) begin
			p.cfg.src = mcmc_src_t'(i);
			p.cfg.rate = ~p.cfg.rate;
			set_pins(p);
			wait_valid(1'b0, 1);
			wait_valid(1'b1, 600);
			if (p.cfg.rate) period(80, 81);
			else period(61, 62);
		end
		p.cfg.src = SRC_8K;
		set_pins(p);
		// Separate T1 clock, so its edges differ from the E1 ones
		single <= 1'b0;
		wait_valid(1'b1, 600);
		@(posedge clk_sys_in);
		t1_stop <= 1'b1;
		repeat (400) @(posedge clk_sys_in);
		chk("master_clock_valid", 1, 32'(valid));
		p.cfg.src = SRC_T1_FULL;
		set_pins(p);
		wait_valid(1'b0, 1);
		repeat (400) @(posedge clk_sys_in);
		chk("master_clock_valid", 0, 32'(valid));
		@(posedge clk_sys_in);
		t1_stop <= 1'b0;
		single <= 1'b1;
	endtask
	task automatic t_host();
		mcmc_pins_t p;
		p = pins;
		p.host_mode = 1'b1;
		p.cfg = 4'h0;
		set_pins(p);
		wb_xfer(1'b1, ADDR_CTRL, 32'h19);
		wb_xfer(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl", 32'h19, q);
		chk("rx_enable", 32'hFF, 32'(rx_en));
		wait_valid(1'b1, 600);
		period(80, 81);
		wb_xfer(1'b0, 8'hFC, 32'h0);
		chk("unmapped", 0, q);
		wb_xfer(1'b1, ADDR_EQ, 32'h1C);
		wb_xfer(1'b0, ADDR_STAT, 32'h0);
		chk("stat_host_t1", 32'h8, q & 32'hC);
		p.hw_reset_n = 1'b0;
		set_pins(p);
		repeat (1235) @(posedge clk_sys_in);
		chk("device_reset", 0, 32'(dres));
		repeat (30) @(posedge clk_sys_in);
		chk("device_reset", 1, 32'(dres));
		chk("master_clock_valid", 0, 32'(valid));
		p.hw_reset_n = 1'b1;
		set_pins(p);
		chk("device_reset", 0, 32'(dres));
		wb_xfer(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl", 0, q);
	endtask
	// Bound on the whole run
	always @(posedge clk_sys_in) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == LIMIT) begin
			failures++;
			finish_test();
		end
	end
	initial begin
		repeat (6) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		@(posedge clk_sys_in);
		chk("master_clock_valid", 0, 32'(valid));
		wait_valid(1'b1, 600);
		t_term();
		t_modes();
		t_clock();
		t_host();
		finish_test();
	end
endmodule
